/* led_fault_ctrl.v */
/*
  System state, fault handling and two-wire serial register slave of a
  five-string LED driver. Assumes analog comparator levels arrive
  asynchronously and the serial wire level is resolved outside.
*/
`timescale 1ns/1ps
`include "led_fault_defines.vh"
module led_fault_ctrl #(
  parameter DEBOUNCE_CYCLES = `DEBOUNCE_US * `CLK_MHZ,
  parameter CNT_W = 20,
  parameter [6:0] DEV_ADDR = `SLAVE_ADDR
) (
  input wire ref_clk,
  input wire srst,
  input wire vdd_ok,
  input wire vin_ok,
  input wire ovp_cmp,
  input wire vout_recovered,
  input wire diode_ok,
  input wire overtemp,
  input wire [4:0] open_cmp,
  input wire [4:0] short_cmp,
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  output reg converter_enable,
  output reg soft_start,
  output reg switch_node_oe,
  output reg [4:0] string_output_oe,
  output reg [4:0] string_enable_bit,
  output reg [2:0] sys_state
);
  localparam [2:0] ST_OFF = 3'd0;
  localparam [2:0] ST_SHUTDOWN = 3'd1;
  localparam [2:0] ST_STANDBY = 3'd2;
  localparam [2:0] ST_CHECK = 3'd3;
  localparam [2:0] ST_ON = 3'd4;

  localparam [2:0] I_IDLE = 3'd0;
  localparam [2:0] I_ADDR = 3'd1;
  localparam [2:0] I_CMD = 3'd2;
  localparam [2:0] I_WDATA = 3'd3;
  localparam [2:0] I_RDATA = 3'd4;

  // configuration registers kept as plain storage
  function is_cfg;
    input [7:0] a;
    begin
      is_cfg = (a >= 8'h03 && a <= 8'h07) || (a >= 8'h0b && a <= 8'h0f) ||
               (a >= 8'h17 && a <= 8'h19);
    end
  endfunction

  wire [`SYNC_W-1:0] sync_out;
  wire scl_s;
  wire sda_s;
  wire vdd_s;
  wire vin_s;
  wire ovp_s;
  wire rec_s;
  wire diode_s;
  wire ot_s;
  wire [4:0] open_s;
  wire [4:0] short_s;

  sync2 #(.W(`SYNC_W)) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .din({scl, sda_in, vdd_ok, vin_ok, ovp_cmp, vout_recovered, diode_ok,
          overtemp, open_cmp, short_cmp}),
    .dout(sync_out)
  ); // R20
  assign {scl_s, sda_s, vdd_s, vin_s, ovp_s, rec_s, diode_s, ot_s, open_s,
          short_s} = sync_out;

  // logic supply low holds everything in reset
  wire rst_all = srst | ~vdd_s; // R2

  reg [2:0] state;
  reg [4:0] en;
  reg [2:0] supply_sel;
  reg [4:0] string_stat;
  reg [2:0] global_stat;
  reg ovp_hold;
  reg need_cmd;
  reg [7:0] cfg_mem [0:31];

  // serial slave state
  reg [2:0] i_state;
  reg [3:0] bit_cnt;
  reg ack_phase;
  reg [7:0] shreg;
  reg [7:0] ptr;
  reg scl_q;
  reg sda_q;
  reg wr_pulse;
  reg [7:0] wr_addr;
  reg [7:0] wr_data;
  reg rd_pulse;
  reg [7:0] rd_addr;
  reg [7:0] rd_val;

  wire start_c = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c = scl_s & scl_q & ~sda_q & sda_s;
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;

  reg [7:0] rd_mux;
  always @* begin
    rd_mux = 8'h00;
    if (ptr == `REG_ONOFF)
      rd_mux = {3'h0, en};
    else if (ptr == `REG_SUPPLY_SEL)
      rd_mux = {5'h0, supply_sel};
    else if (ptr == `REG_STRING_STAT)
      rd_mux = {3'h0, string_stat};
    else if (ptr == `REG_GLOBAL_STAT)
      rd_mux = {5'h0, global_stat};
    else if (is_cfg(ptr))
      rd_mux = cfg_mem[ptr[4:0]];
  end

  // two-wire slave: the only path to the registers
  always @(posedge ref_clk) begin
    if (rst_all) begin
      i_state <= I_IDLE;
      bit_cnt <= 4'd0;
      ack_phase <= 1'b0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      wr_pulse <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      rd_pulse <= 1'b0;
      rd_addr <= 8'h00;
      rd_val <= 8'h00;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      wr_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      if (start_c) begin
        i_state <= I_ADDR;
        bit_cnt <= 4'd0;
        ack_phase <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        i_state <= I_IDLE;
        sda_oe <= 1'b0;
      end else if (i_state != I_IDLE && scl_rise) begin
        if (bit_cnt < 4'd8) begin
          shreg <= {shreg[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'd1;
        end else if (i_state == I_RDATA && ack_phase && sda_s) begin
          // master declined more data
          i_state <= I_IDLE;
          sda_oe <= 1'b0;
        end
      end else if (i_state != I_IDLE && scl_fall) begin
        if (bit_cnt == 4'd8 && !ack_phase) begin
          ack_phase <= 1'b1;
          case (i_state)
            I_ADDR: begin
              if (shreg[7:1] == DEV_ADDR) begin
                sda_oe <= 1'b1; // R19
                i_state <= shreg[0] ? I_RDATA : I_CMD;
              end else begin
                i_state <= I_IDLE;
              end
            end
            I_CMD: begin
              ptr <= shreg;
              sda_oe <= 1'b1;
              i_state <= I_WDATA;
            end
            I_WDATA: begin
              wr_pulse <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shreg;
              ptr <= ptr + 8'd1;
              sda_oe <= 1'b1;
            end
            default: sda_oe <= 1'b0;
          endcase
        end else if (bit_cnt == 4'd8) begin
          ack_phase <= 1'b0;
          bit_cnt <= 4'd0;
          if (i_state == I_RDATA) begin
            // fetch and present the next byte; pointer moves on
            shreg <= rd_mux;
            sda_oe <= ~rd_mux[7];
            rd_pulse <= 1'b1;
            rd_addr <= ptr;
            rd_val <= rd_mux;
            ptr <= ptr + 8'd1;
          end else begin
            sda_oe <= 1'b0;
          end
        end else if (i_state == I_RDATA) begin
          sda_oe <= ~shreg[7];
        end
      end
    end
  end

  wire wr_onoff = wr_pulse && wr_addr == `REG_ONOFF;
  wire [4:0] rd_clr1 = (rd_pulse && rd_addr == `REG_STRING_STAT) ? rd_val[4:0] : 5'h0;
  wire [2:0] rd_clr2 = (rd_pulse && rd_addr == `REG_GLOBAL_STAT) ? rd_val[2:0] : 3'h0;

  // strings 3..5 on an alternate supply lose short detection
  wire [4:0] alt_src = {supply_sel, 2'b00}; // R9
  wire run = (state == ST_ON);
  wire [4:0] raw_fault = en & {5{run}} & (open_s | (short_s & ~alt_src)); // R4 R5 R6
  wire [4:0] expire;

  genvar g;
  generate
    for (g = 0; g < `NUM_STRINGS; g = g + 1) begin : g_deb
      fault_debounce #(.CYCLES(DEBOUNCE_CYCLES), .CNT_W(CNT_W)) u_deb (
        .ref_clk(ref_clk),
        .rst(rst_all),
        .fault(raw_fault[g]),
        .expired(expire[g])
      );
    end
  endgenerate

  wire ovp_ev = ovp_s & run; // R10
  wire ot_ev = ot_s & (state == ST_STANDBY || state == ST_CHECK || run); // R13
  wire diode_ev = (state == ST_CHECK) & ~diode_s; // R12
  wire gevt = ovp_ev | ot_ev | diode_ev;

  reg [4:0] next_en;
  reg [2:0] next_state;
  reg [2:0] next_gstat;
  always @* begin
    next_en = en;
    if (wr_onoff)
      next_en = wr_data[4:0]; // R18
    next_en = next_en | rd_clr1; // R14
    next_en = next_en & ~expire; // R7
    // fault clear wins over a same-cycle host write, for safety
    if (gevt)
      next_en = 5'h00; // R10 R12 R13
    next_gstat = global_stat & ~rd_clr2;
    next_gstat[`GST_OVP] = next_gstat[`GST_OVP] | ovp_ev;
    next_gstat[`GST_OT] = next_gstat[`GST_OT] | ot_ev;
    next_gstat[`GST_DIODE] = next_gstat[`GST_DIODE] | diode_ev;
    next_state = state;
    case (state)
      ST_OFF, ST_SHUTDOWN: begin
        if (vin_s)
          next_state = ST_STANDBY; // R3
      end
      ST_STANDBY: begin
        if (!vin_s)
          next_state = ST_OFF;
        else if (|en && global_stat == 3'h0 && !need_cmd && !ovp_hold && !ot_s)
          next_state = ST_CHECK; // R1 R11 R16
      end
      ST_CHECK: begin
        // output sensed before switching starts
        if (gevt)
          next_state = ST_STANDBY; // R12
        else
          next_state = ST_ON;
      end
      ST_ON: begin
        if (!vin_s)
          next_state = ST_OFF;
        else if (gevt || next_en == 5'h00)
          next_state = ST_STANDBY; // R10 R13
      end
      default: next_state = ST_OFF;
    endcase
  end

  wire conv_next = (next_state == ST_ON) & (|next_en); // R21

  always @(posedge ref_clk) begin
    if (rst_all) begin
      // catch supply levels while held, after synchronising
      state <= (srst || !vin_s) ? ST_OFF : ST_SHUTDOWN; // R2
      sys_state <= (srst || !vin_s) ? ST_OFF : ST_SHUTDOWN;
      en <= `ONOFF_RST;
      supply_sel <= `SUPPLY_SEL_RST;
      string_stat <= 5'h00;
      global_stat <= 3'h0;
      ovp_hold <= 1'b0;
      need_cmd <= 1'b0;
      converter_enable <= 1'b0;
      soft_start <= 1'b0;
      switch_node_oe <= 1'b0;
      string_output_oe <= 5'h00;
      string_enable_bit <= 5'h00;
    end else begin
      state <= next_state;
      sys_state <= next_state;
      en <= next_en;
      string_enable_bit <= next_en;
      if (wr_pulse && wr_addr == `REG_SUPPLY_SEL)
        supply_sel <= wr_data[2:0];
      // new events win over a clearing read; global events mask string ones
      string_stat <= (string_stat & ~rd_clr1) | (expire & {5{~gevt}}); // R7 R8 R15
      global_stat <= next_gstat; // R10 R12 R13
      if (ovp_ev)
        ovp_hold <= 1'b1;
      else if (rec_s)
        ovp_hold <= 1'b0; // R11
      // a fresh enable command is needed once global faults are read out
      if (gevt)
        need_cmd <= 1'b1;
      else if (wr_onoff && global_stat == 3'h0 && |wr_data[4:0])
        need_cmd <= 1'b0; // R16
      converter_enable <= conv_next; // R21
      soft_start <= conv_next & ~converter_enable; // R1
      switch_node_oe <= conv_next; // R17
      string_output_oe <= next_en & {5{conv_next}}; // R17
    end
  end

  // configuration bytes are stored only; they have no effect in this block
  integer k;
  always @(posedge ref_clk) begin
    if (rst_all) begin
      for (k = 0; k < 32; k = k + 1)
        cfg_mem[k] <= `CFG_RST;
    end else if (wr_pulse && is_cfg(wr_addr)) begin
      cfg_mem[wr_addr[4:0]] <= wr_data;
    end
  end
endmodule // led_fault_ctrl

/* led_fault_defines.vh */
/*
  Shared constants for the LED string fault and system state controller:
  serial slave address, register offsets, field positions, reset values, timing.
  Assumes inclusion by bare name from the controller design file only; the other files of the block do not include it.
*/
// How it works
// R1 - standby with an enable bit set starts the converter via soft-start
// R2 - logic supply low holds registers in reset, converter and strings off
// R3 - logic supply valid and input supply above lockout gives standby
// R4 - per string: open when pin low, short when pin near output
// R5 - open and short inputs count only while that string is enabled
// R6 - open or short merge into one per-string status bit, 1 is fault
// R7 - fault held for debounce time latches status and clears enable
// R8 - overvoltage before debounce expiry reports only the overvoltage
// R9 - strings three to five on alternate supply do open detection only
// R10 - overvoltage clears enables, stops converter, standby, global bit 0
// R11 - converter may restart after output falls below recovery level
// R12 - output below diode-check level before start: standby, global bit 2
// R13 - overtemperature clears enables, stops converter, standby, global bit 1
// R14 - reading string status clears it and re-enables faulted strings
// R15 - persistent string fault sets its bit again after fresh debounce
// R16 - after global fault: read global status, then write an enable
// R17 - converter off keeps switch node and string outputs high impedance
// R18 - host writes 1 to enable a string, 0 to disable it
// R19 - registers are reached only through the two-wire serial slave
// R20 - comparators synchronised; debounce restarts when the fault drops
// R21 - converter enable only in on state with a string enabled
`ifndef LED_FAULT_DEFINES_VH
`define LED_FAULT_DEFINES_VH
`define CLK_MHZ 50
`define DEBOUNCE_US 16000
`define SLAVE_ADDR 7'h4d
`define REG_ONOFF 8'h00
`define REG_SUPPLY_SEL 8'h1a
`define REG_STRING_STAT 8'h1b
`define REG_GLOBAL_STAT 8'h1c
`define GST_OVP 0
`define GST_OT 1
`define GST_DIODE 2
`define ONOFF_RST 5'h00
`define SUPPLY_SEL_RST 3'h0
`define CFG_RST 8'h00
`define NUM_STRINGS 5
`define SYNC_W 18
`endif

/* sync2.v */
/*
  Two flip-flop synchroniser for a vector of asynchronous levels.
  Assumes each bit is an independent level; no word coherence across bits.
*/
`timescale 1ns/1ps
module sync2 #(
  parameter W = 1
) (
  input wire ref_clk,
  input wire srst,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] meta;

  always @(posedge ref_clk) begin
    if (srst) begin
      meta <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // sync2

/* fault_debounce.v */
/*
  Debounce timer for one string fault level: pulses once when the level
  has stood for CYCLES clocks. Assumes the input is already synchronised.
*/
`timescale 1ns/1ps
module fault_debounce #(
  parameter CYCLES = 800000,
  parameter CNT_W = 20
) (
  input wire ref_clk,
  input wire rst,
  input wire fault,
  output reg expired
);
  reg [CNT_W-1:0] cnt;

  always @(posedge ref_clk) begin
    if (rst) begin
      cnt <= {CNT_W{1'b0}};
      expired <= 1'b0;
    end else if (!fault) begin
      // any drop restarts the interval
      cnt <= {CNT_W{1'b0}}; // R20
      expired <= 1'b0;
    end else if (cnt == CYCLES[CNT_W-1:0] - 1'b1) begin
      cnt <= CYCLES[CNT_W-1:0];
      expired <= 1'b1; // R7
    end else begin
      // saturates at CYCLES so one held fault pulses once
      cnt <= (cnt == CYCLES[CNT_W-1:0]) ? cnt : cnt + 1'b1;
      expired <= 1'b0;
    end
  end
endmodule // fault_debounce

/* led_fault_ctrl_assertions.sv */
/*
  Checker for the LED fault controller: state, converter and fault reactions.
  Assumes a bind to every controller instance; ports as the controller's.
*/
`timescale 1ns/1ps
module led_fault_ctrl_checker (
  input wire ref_clk,
  input wire srst,
  input wire vdd_ok,
  input wire vin_ok,
  input wire ovp_cmp,
  input wire overtemp,
  input wire diode_ok,
  input wire soft_start,
  input wire converter_enable,
  input wire switch_node_oe,
  input wire [4:0] string_output_oe,
  input wire [4:0] string_enable_bit,
  input wire [2:0] sys_state
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_conv_needs_on: assert property (
    converter_enable |-> sys_state == 3'd4 && |string_enable_bit)
    else $error("converter on outside on state");
  a_off_is_hiz: assert property (
    !converter_enable |-> !switch_node_oe && string_output_oe == 5'h00)
    else $error("outputs driven while converter off");
  a_switch_follows: assert property (
    switch_node_oe == converter_enable)
    else $error("switch node enable differs from converter");
  a_soft_pulse: assert property (
    soft_start |-> converter_enable && !$past(converter_enable) ##1 !soft_start)
    else $error("soft start not a single pulse at converter start");
  a_ovp_stops: assert property (
    (ovp_cmp && sys_state == 3'd4) [*3] |-> ##[0:3]
    (sys_state == 3'd2 && string_enable_bit == 5'h00 && !converter_enable))
    else $error("overvoltage did not force standby");
  a_ot_stops: assert property (
    overtemp [*4] |-> ##[0:3] (string_enable_bit == 5'h00 && !converter_enable))
    else $error("overtemperature did not stop the converter");
  a_diode_check: assert property (
    (!diode_ok) [*4] ##0 sys_state == 3'd3 |=> sys_state == 3'd2 && !converter_enable)
    else $error("open diode did not force standby");
  a_logic_low: assert property (
    (!vdd_ok) [*5] |-> string_enable_bit == 5'h00 && !converter_enable && sys_state < 3'd2)
    else $error("logic supply low did not hold reset");
  a_state_legal: assert property (
    (vdd_ok && vin_ok) [*5] |-> sys_state >= 3'd2 && sys_state <= 3'd4)
    else $error("supplies valid but not in standby or on");
  a_soft_on_start: assert property (
    $rose(converter_enable) |-> soft_start)
    else $error("converter started without soft start");
endmodule // led_fault_ctrl_checker

bind led_fault_ctrl led_fault_ctrl_checker checker_i (.ref_clk, .srst, .vdd_ok, .ovp_cmp,
  .overtemp, .diode_ok, .soft_start, .converter_enable, .switch_node_oe, .string_output_oe,
  .string_enable_bit, .sys_state, .vin_ok);

/* serial_host.sv */
/*
  Two-wire serial host model: register writes and pointer-then-read cycles.
  Assumes a pull-up on the data wire; the wire is resolved here.
*/
`timescale 1ns/1ps
module serial_host #(
  parameter [6:0] DEV_ADDR = 7'h4d
) (
  input wire ref_clk,
  input wire sda_oe,
  input wire sda_out,
  output reg scl,
  output wire sda_in
);
  reg sda_o;
  // pull-up wins unless someone pulls low
  assign sda_in = sda_o & (sda_oe ? sda_out : 1'b1);
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  // phases of 10 clocks keep above the 8-clock minimum
  task ph;
    repeat (10) @(posedge ref_clk);
    #1;
  endtask
  task start;
    ph; sda_o = 1'b1; ph; scl = 1'b1; ph; sda_o = 1'b0; ph; scl = 1'b0;
  endtask
  task stop;
    ph; sda_o = 1'b0; ph; scl = 1'b1; ph; sda_o = 1'b1; ph;
  endtask
  task bit_io(input reg b, output reg r);
    ph; sda_o = b; ph; scl = 1'b1; ph; r = sda_in; scl = 1'b0;
  endtask
  task xfer(input [7:0] d, output [7:0] q, output reg ack);
    integer i;
    reg r;
    for (i = 7; i >= 0; i = i - 1) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task wr(input [7:0] a, input [7:0] d, output reg ok);
    reg [7:0] q;
    reg k1, k2, k3;
    start; xfer({DEV_ADDR, 1'b0}, q, k1); xfer(a, q, k2); xfer(d, q, k3); stop;
    ok = k1 & k2 & k3;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    reg [7:0] q;
    reg k;
    start; xfer({DEV_ADDR, 1'b0}, q, k); xfer(a, q, k);
    start; xfer({DEV_ADDR, 1'b1}, q, k); xfer(8'hff, d, k); stop;
  endtask
endmodule // serial_host

/* test_led_fault_ctrl.sv */
/*
  Self-checking bench for the LED fault controller, driven over the serial host.
  Assumes a shortened debounce count; all expectations derive from it.
*/
`timescale 1ns/1ps
module test_led_fault_ctrl;
  localparam DEB = 20;
  reg ref_clk, srst, vdd_ok, vin_ok, ovp_cmp, vout_recovered, diode_ok, overtemp;
  reg [4:0] open_cmp, short_cmp;
  wire scl, sda_in, sda_out, sda_oe, converter_enable, soft_start, switch_node_oe;
  wire [4:0] string_output_oe, string_enable_bit;
  wire [2:0] sys_state;
  integer n_fail, n_compared, k;
  reg [7:0] q;
  reg ok;
  led_fault_ctrl #(.DEBOUNCE_CYCLES(DEB)) dut (.ref_clk, .srst, .vdd_ok, .vin_ok, .ovp_cmp,
    .vout_recovered, .diode_ok, .overtemp, .open_cmp, .short_cmp, .scl, .sda_in, .sda_out,
    .sda_oe, .converter_enable, .soft_start, .switch_node_oe, .string_output_oe,
    .string_enable_bit, .sys_state);
  serial_host host (.ref_clk, .sda_oe, .sda_out, .scl, .sda_in);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task tick(input integer n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task compare(input [7:0] got, input [7:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rd_chk(input [7:0] a, input [7:0] exp);
    host.rd(a, q);
    compare(q, exp);
  endtask
  task state_chk(input [2:0] st, input [4:0] en, input cv);
    compare(sys_state, st);
    compare(string_enable_bit, en);
    compare(converter_enable, cv);
  endtask
  task tally_and_finish;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // whole run needs roughly 31k clocks
  initial begin
    repeat (90000) @(posedge ref_clk);
    n_fail = n_fail + 1;
    tally_and_finish;
  end
  initial begin
    n_fail = 0; n_compared = 0; srst = 1'b1; vdd_ok = 1'b1; vin_ok = 1'b1; ovp_cmp = 1'b0;
    vout_recovered = 1'b1; diode_ok = 1'b1; overtemp = 1'b0; open_cmp = 0; short_cmp = 0;
    tick(16);
    srst = 1'b0;
    tick(4);
    state_chk(3'd2, 5'h00, 1'b0);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h10, 8'h00);
    host.wr(8'h0b, 8'h5a, ok);
    rd_chk(8'h0b, 8'h5a);
    open_cmp = 5'h1f; short_cmp = 5'h1f; tick(DEB + 6);
    rd_chk(8'h1b, 8'h00);
    open_cmp = 0; short_cmp = 0;
    $display("test standby done");
    host.wr(8'h00, 8'h1f, ok);
    compare(ok, 1'b1);
    tick(4);
    state_chk(3'd4, 5'h1f, 1'b1);
    compare(string_output_oe, 5'h1f);
    // glitches summing past the debounce must not latch
    open_cmp = 5'h01; tick(14); open_cmp = 0; tick(3); open_cmp = 5'h01; tick(14);
    open_cmp = 0; tick(4);
    compare(string_enable_bit, 5'h1f);
    open_cmp = 5'h01; tick(DEB + 6);
    compare(string_enable_bit, 5'h1e);
    rd_chk(8'h1b, 8'h01);
    rd_chk(8'h1b, 8'h01);
    open_cmp = 0;
    rd_chk(8'h1b, 8'h01);
    compare(string_enable_bit, 5'h1f);
    host.wr(8'h1a, 8'h01, ok);
    short_cmp = 5'h0c; tick(DEB + 6);
    compare(string_enable_bit, 5'h17);
    short_cmp = 0;
    rd_chk(8'h1b, 8'h08);
    $display("test string faults done");
    for (k = 0; k < 3; k = k + 1) begin
      if (k == 2)
        diode_ok = 1'b0;
      tick(4);
      host.wr(8'h00, 8'h1f, ok);
      if (k == 0) begin
        open_cmp = 5'h02;
        tick(8);
        ovp_cmp = 1'b1;
        // output stays high after the overvoltage until told otherwise
        vout_recovered = 1'b0;
      end
      if (k == 1) begin
        compare(sys_state, 3'd2);
        vout_recovered = 1'b1;
        tick(6);
        compare(sys_state, 3'd4);
        overtemp = 1'b1;
      end
      tick(10);
      state_chk(3'd2, 5'h00, 1'b0);
      ovp_cmp = 1'b0; overtemp = 1'b0; diode_ok = 1'b1; open_cmp = 0;
      host.wr(8'h00, 8'h1f, ok);
      tick(4);
      compare(sys_state, 3'd2);
      compare(converter_enable, 1'b0);
      rd_chk(8'h1b, 8'h00);
      rd_chk(8'h1c, 8'h01 << k);
      rd_chk(8'h1c, 8'h00);
    end
    host.wr(8'h00, 8'h1f, ok);
    tick(4);
    state_chk(3'd4, 5'h1f, 1'b1);
    $display("test global faults done");
    vdd_ok = 1'b0; tick(8);
    state_chk(3'd1, 5'h00, 1'b0);
    compare(switch_node_oe, 1'b0);
    vdd_ok = 1'b1; tick(8);
    state_chk(3'd2, 5'h00, 1'b0);
    rd_chk(8'h1a, 8'h00);
    vin_ok = 1'b0; tick(8);
    compare(sys_state, 3'd0);
    vin_ok = 1'b1; tick(8);
    $display("test supplies done");
    tally_and_finish;
  end
endmodule // test_led_fault_ctrl
